// ===== hdl/sshp_host_port.sv
// serial host port: four-wire link, two-wire slave and register core
//
// Operation
// R1: select high aborts and resets the port
// R2: port active only while select low
// R3: host frames every transaction with select
// R4: write is direction one, address, data
// R5: input sampled on every rising clock
// R6: read is direction zero address, data returned
// R7: output changes on falling edges, held
// R8: host waits address-to-data delay before data
// R9: host spaces write to write
// R10: host spaces write to read
// R11: host waits after read before next
// R12: mode value 0x10 at 0x1c enables burst
// R13: burst streams seven bytes in order; the code sends delta_y before delta_x
// R14: host may end burst after three bytes
// R15: burst data captured after address received
// R16: after burst select high exit time
// R17: two-wire id chosen by two straps
// R18: data line driven only ack or read
// R19: host makes start and stop conditions
// R20: receiver drives acknowledge after each byte
// R21: packets eight bits, msb first
// R22: address packet then direction bit
// R23: address-to-data delay at least 4 us
// R24: write to write at least 30 us
// R25: write to read at least 20 us
// R26: after read at least 500 ns
`timescale 1ns/1ns
module sshp_host_port (
  // core clock and reset
  input  logic                 clk,
  input  logic                 rst_n,
  // four-wire link
  input  logic                 sclk,
  input  logic                 port_select_n,
  input  logic                 mosi,
  output logic                 miso_out,
  output logic                 miso_oe,
  // two-wire link
  input  logic                 scl,
  input  logic                 sda_in,
  output logic                 sda_out,
  output logic                 sda_oe,
  // address straps
  input  logic                 strap_addr_sel_low,
  input  logic                 strap_addr_sel_high,
  // navigation data and status
  input  sshp_pkg::sshp_nav_s  nav,
  output logic                 burst_locked
);

  logic [1:0]           rst_q;
  logic                 core_rst_n;
  logic                 frame_rst_n;
  sshp_pkg::sshp_core_s s_reg;
  sshp_pkg::sshp_core_s s_next;
  sshp_pkg::sshp_wr_s   wr_hold;
  logic                 wr_tog;
  logic [6:0]           rd_addr;
  logic                 rd_tog;
  logic [6:0]           sync_in;
  logic [6:0]           sync_out;
  logic                 sel_n_s;
  logic                 rd_tog_s;
  logic                 wr_tog_s;
  logic                 scl_s;
  logic                 sda_s;
  logic                 rise;
  logic                 fall;
  logic                 start;
  logic                 stop;
  logic [6:0]           nxt_addr;

  // reads of the live motion registers come from the navigation engine
  function automatic logic [7:0] reg_rd(
    input logic [127:0][7:0]    r,
    input sshp_pkg::sshp_nav_s  n,
    input logic [6:0]           a
  );
    case (a)
      sshp_pkg::MOTION_BURST_SOURCE_ADDR: reg_rd = n.motion;
      sshp_pkg::DELTA_X_ADDR:             reg_rd = n.delta_x;
      sshp_pkg::DELTA_Y_ADDR:             reg_rd = n.delta_y;
      sshp_pkg::SURFACE_QUALITY_ADDR:     reg_rd = n.surface_quality_count;
      sshp_pkg::SHUTTER_HI_ADDR:          reg_rd = n.shutter_hi;
      sshp_pkg::SHUTTER_LO_ADDR:          reg_rd = n.shutter_lo;
      sshp_pkg::MAX_PIXEL_ADDR:           reg_rd = n.max_pixel;
      default:                            reg_rd = r[a];
    endcase
  endfunction

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  assign core_rst_n  = rst_q[1];
  assign frame_rst_n = core_rst_n && !port_select_n; // R1 R2

  sshp_spi_link u_link (
    .sclk        (sclk),
    .frame_rst_n (frame_rst_n),
    .sys_rst_n   (core_rst_n),
    .mosi        (mosi),
    .miso_out    (miso_out),
    .miso_oe     (miso_oe),
    .rd_buf      (s_reg.rd),
    .wr_hold     (wr_hold),
    .wr_tog      (wr_tog),
    .rd_addr     (rd_addr),
    .rd_tog      (rd_tog)
  );

  assign sync_in = {port_select_n, rd_tog, wr_tog, scl, sda_in,
                    strap_addr_sel_low, strap_addr_sel_high};

  sshp_sync3 #(
    .W   (7),
    .RST (sshp_pkg::SYNC_RST)
  ) u_sync (
    .clk   (clk),
    .rst_n (core_rst_n),
    .d     (sync_in),
    .q     (sync_out)
  );

  assign sel_n_s  = sync_out[6];
  assign rd_tog_s = sync_out[5];
  assign wr_tog_s = sync_out[4];
  assign scl_s    = sync_out[3];
  assign sda_s    = sync_out[2];

  always_comb begin
    s_next   = s_reg;
    rise     = scl_s && !s_reg.scl_q;
    fall     = !scl_s && s_reg.scl_q;
    start    = s_reg.scl_q && scl_s && s_reg.sda_q && !sda_s; // R19
    stop     = s_reg.scl_q && scl_s && !s_reg.sda_q && sda_s; // R19
    nxt_addr = s_reg.ai ? s_reg.taddr + 7'h01 : s_reg.taddr;
    s_next.scl_q = scl_s;
    s_next.sda_q = sda_s;

    // straps followed from one cycle after reset, while the filter may still hold its reset pattern
    s_next.id_done = 1'b1;
    if (s_reg.id_done) begin
      s_next.slave_id = sshp_pkg::SLAVE_IDS[sync_out[1:0]]; // R17
    end

    // four-wire write, refused while a burst is not yet exited
    if (wr_tog_s != s_reg.wr_seen) begin
      s_next.wr_seen = wr_tog_s;
      if (!s_reg.locked) begin
        s_next.regs[wr_hold.addr] = wr_hold.data; // R4 R12
      end
    end

    // four-wire read: single byte or burst snapshot
    if (rd_tog_s != s_reg.rd_seen) begin
      s_next.rd_seen = rd_tog_s;
      s_next.rd      = '0;
      if (!s_reg.locked) begin
        if (rd_addr == sshp_pkg::MOTION_BURST_SOURCE_ADDR
            && s_reg.regs[sshp_pkg::PORT_IO_MODE_ADDR]
               == sshp_pkg::BURST_ENABLE_VAL) begin
          s_next.rd.burst = 1'b1; // R12
          s_next.rd.data  = nav; // R13 R15
          s_next.locked   = 1'b1; // R16
          s_next.exit_cnt = '0;
        end else begin
          s_next.rd.data[55:48] = reg_rd(s_reg.regs, nav, rd_addr); // R6
        end
      end
    end

    // burst exit: select must stay high for the exit time
    if (s_reg.locked && sel_n_s) begin
      if (s_reg.exit_cnt == sshp_pkg::BURST_EXIT_CYC - 8'h01) begin
        s_next.locked = 1'b0; // R16
      end else begin
        s_next.exit_cnt = s_reg.exit_cnt + 8'h01;
      end
    end else begin
      s_next.exit_cnt = '0; // R14 R16
    end

    // two-wire slave
    if (start) begin
      s_next.ts     = sshp_pkg::T_DEV; // R19
      s_next.cnt    = '0;
      s_next.sda_oe = 1'b0;
    end else if (stop) begin
      s_next.ts     = sshp_pkg::T_IDLE; // R19
      s_next.sda_oe = 1'b0;
    end else begin
      case (s_reg.ts)
        sshp_pkg::T_IDLE: begin
          s_next.sda_oe = 1'b0;
        end
        sshp_pkg::T_DEV, sshp_pkg::T_REG, sshp_pkg::T_WDAT: begin
          if (rise && s_reg.cnt != sshp_pkg::TWI_BITS) begin
            s_next.sh  = {s_reg.sh[6:0], sda_s}; // R21
            s_next.cnt = s_reg.cnt + 4'h1;
          end else if (fall && s_reg.cnt == sshp_pkg::TWI_BITS) begin
            s_next.cnt    = '0;
            s_next.ts     = sshp_pkg::T_ACK;
            s_next.sda_oe = 1'b1; // R18 R20
            s_next.ack_to = sshp_pkg::T_WDAT;
            if (s_reg.ts == sshp_pkg::T_DEV) begin
              if (s_reg.sh[7:1] == s_reg.slave_id) begin // R17 R22
                s_next.ack_to = s_reg.sh[sshp_pkg::RW_BIT]
                                ? sshp_pkg::T_RDAT
                                : sshp_pkg::T_REG; // R22
              end else begin
                s_next.ts     = sshp_pkg::T_IDLE;
                s_next.sda_oe = 1'b0; // R18
              end
            end else if (s_reg.ts == sshp_pkg::T_REG) begin
              s_next.taddr = s_reg.sh[6:0];
              s_next.ai    = s_reg.sh[sshp_pkg::AI_BIT];
            end else begin
              s_next.regs[s_reg.taddr] = s_reg.sh;
              s_next.taddr = nxt_addr;
            end
          end
        end
        sshp_pkg::T_ACK: begin
          if (fall) begin
            s_next.sda_oe = 1'b0;
            s_next.cnt    = '0;
            s_next.ts     = s_reg.ack_to;
            if (s_reg.ack_to == sshp_pkg::T_RDAT) begin
              s_next.tx     = reg_rd(s_reg.regs, nav, s_reg.taddr);
              s_next.sda_oe = !s_next.tx[7]; // R18 R21
              s_next.cnt    = 4'h1;
            end
          end
        end
        sshp_pkg::T_RDAT: begin
          if (fall) begin
            if (s_reg.cnt == sshp_pkg::TWI_BITS) begin
              s_next.sda_oe = 1'b0; // R20
              s_next.ts     = sshp_pkg::T_MACK;
            end else begin
              s_next.sda_oe = !s_reg.tx[3'(4'h7 - s_reg.cnt)]; // R21
              s_next.cnt    = s_reg.cnt + 4'h1;
            end
          end
        end
        sshp_pkg::T_MACK: begin
          if (rise) begin
            s_next.mack_ok = !sda_s; // R20
          end else if (fall) begin
            if (s_reg.mack_ok) begin
              s_next.taddr  = nxt_addr;
              s_next.tx     = reg_rd(s_reg.regs, nav, nxt_addr);
              s_next.sda_oe = !s_next.tx[7]; // R18
              s_next.cnt    = 4'h1;
              s_next.ts     = sshp_pkg::T_RDAT;
            end else begin
              s_next.ts = sshp_pkg::T_IDLE;
            end
          end
        end
        default: begin
          s_next.ts     = sshp_pkg::T_IDLE;
          s_next.sda_oe = 1'b0;
        end
      endcase
    end
    s_next.sda_lvl = 1'b0;
  end

  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      s_reg          <= '0;
      s_reg.regs     <= {128{sshp_pkg::REG_RST}};
      s_reg.scl_q    <= 1'b1;
      s_reg.sda_q    <= 1'b1;
      s_reg.ts       <= sshp_pkg::T_IDLE;
      s_reg.ack_to   <= sshp_pkg::T_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sda_out      = s_reg.sda_lvl;
  assign sda_oe       = s_reg.sda_oe;
  assign burst_locked = s_reg.locked;

endmodule

// ===== hdl/sshp_spi_link.sv
// four-wire link logic on the serial clock
`timescale 1ns/1ns
module sshp_spi_link (
  // link clock and resets
  input  logic                sclk,
  input  logic                frame_rst_n,
  input  logic                sys_rst_n,
  // serial pins
  input  logic                mosi,
  output logic                miso_out,
  output logic                miso_oe,
  // core side
  input  sshp_pkg::sshp_rd_s  rd_buf,
  output sshp_pkg::sshp_wr_s  wr_hold,
  output logic                wr_tog,
  output logic [6:0]          rd_addr,
  output logic                rd_tog
);

  sshp_pkg::sshp_spi_s s_reg;
  sshp_pkg::sshp_spi_s s_next;
  logic [7:0]          byte_in;
  logic                addr_end;
  logic                wr_end;
  logic                rd_phase;
  logic [5:0]          bit_idx;

  always_comb begin
    byte_in  = {s_reg.sh[6:0], mosi};
    addr_end = !s_reg.done && s_reg.cnt == sshp_pkg::ADDR_LAST;
    wr_end   = !s_reg.done && s_reg.wr_dir
               && s_reg.cnt == sshp_pkg::WR_LAST;
    rd_phase = !s_reg.done && !s_reg.wr_dir
               && s_reg.cnt >= sshp_pkg::DATA_FIRST;
    bit_idx  = sshp_pkg::BURST_MSB
               - 6'(s_reg.cnt - sshp_pkg::DATA_FIRST);
    s_next   = s_reg;
    if (!s_reg.done) begin
      s_next.sh  = byte_in; // R5
      s_next.cnt = s_reg.cnt + 7'h01;
      if (addr_end) begin
        s_next.wr_dir = byte_in[sshp_pkg::DIR_BIT]; // R4 R6
      end
      if (wr_end) begin
        s_next.cnt = '0;
      end
      if (rd_phase && !rd_buf.burst
          && s_reg.cnt == sshp_pkg::RD_LAST) begin
        s_next.cnt = '0;
      end
      if (rd_phase && rd_buf.burst
          && s_reg.cnt == sshp_pkg::BURST_LAST) begin
        s_next.done = 1'b1; // R13 R16
      end
    end
  end

  // select high clears the frame state
  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      s_reg <= '0; // R1 R2
    end else begin
      s_reg <= s_next;
    end
  end

  // commands handed to the core as toggles with held words
  always_ff @(posedge sclk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      wr_hold <= '0;
      wr_tog  <= 1'b0;
      rd_addr <= '0;
      rd_tog  <= 1'b0;
    end else begin
      if (addr_end && !byte_in[sshp_pkg::DIR_BIT]) begin
        rd_addr <= byte_in[6:0]; // R6
        rd_tog  <= !rd_tog;
      end
      if (addr_end && byte_in[sshp_pkg::DIR_BIT]) begin
        wr_hold.addr <= byte_in[6:0]; // R4
      end
      if (wr_end) begin
        wr_hold.data <= byte_in; // R4
        wr_tog       <= !wr_tog;
      end
    end
  end

  // data out on falling edges, held to the next fall
  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
    end else begin
      miso_out <= rd_buf.data[bit_idx]; // R7 R8
      miso_oe  <= rd_phase; // R7
    end
  end

endmodule

// ===== hdl/sshp_sync3.sv
// three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ns
module sshp_sync3 #(
  parameter int         W   = 1,
  parameter logic [6:0] RST = '0
) (
  // clock and reset
  input  logic         clk,
  input  logic         rst_n,
  // levels
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= RST[W-1:0];
      s2_reg <= RST[W-1:0];
      s3_reg <= RST[W-1:0];
      q      <= RST[W-1:0];
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule

// ===== shared/sshp_pkg.sv
// constants, carriers and state types of the sensor serial host port
package sshp_pkg;

  // core clock and burst exit time
  localparam int CLK_MHZ          = 250;
  localparam int BURST_EXIT_TIME_NS = 500;
  localparam int BURST_EXIT_CYC_I =
    (BURST_EXIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] BURST_EXIT_CYC = 8'(BURST_EXIT_CYC_I);

  // host-side spacing, least values
  localparam int READ_ADDR_TO_DATA_DELAY_NS = 4000;
  localparam int WRITE_TO_WRITE_INTERVAL_NS = 30000;
  localparam int WRITE_TO_READ_INTERVAL_NS  = 20000;
  localparam int READ_TO_READ_INTERVAL_NS   = 500;
  localparam int READ_TO_WRITE_INTERVAL_NS  = 500;

  // register map
  localparam logic [6:0] MOTION_BURST_SOURCE_ADDR = 7'h02;
  localparam logic [6:0] DELTA_X_ADDR             = 7'h03;
  localparam logic [6:0] DELTA_Y_ADDR             = 7'h04;
  localparam logic [6:0] SURFACE_QUALITY_ADDR     = 7'h05;
  localparam logic [6:0] SHUTTER_HI_ADDR          = 7'h06;
  localparam logic [6:0] SHUTTER_LO_ADDR          = 7'h07;
  localparam logic [6:0] MAX_PIXEL_ADDR           = 7'h08;
  localparam logic [6:0] PORT_IO_MODE_ADDR        = 7'h1c;
  localparam logic [7:0] PORT_IO_MODE_RST         = 8'h00;
  localparam logic [7:0] BURST_ENABLE_VAL         = 8'h10;
  localparam logic [7:0] REG_RST                  = 8'h00;

  // field positions
  localparam int DIR_BIT = 7;
  localparam int AI_BIT  = 7;
  localparam int RW_BIT  = 0;

  // four-wire link bit counts
  localparam logic [6:0] ADDR_LAST  = 7'h07;
  localparam logic [6:0] WR_LAST    = 7'h0f;
  localparam logic [6:0] RD_LAST    = 7'h0f;
  localparam logic [6:0] BURST_LAST = 7'h3f;
  localparam logic [6:0] DATA_FIRST = 7'h08;
  localparam logic [5:0] BURST_MSB  = 6'h37;

  // two-wire slave ids, indexed by {low strap, high strap}
  localparam logic [3:0][6:0] SLAVE_IDS =
    {7'h57, 7'h53, 7'h3b, 7'h33};
  localparam logic [3:0] TWI_BITS = 4'h8;

  // sync reset pattern: select, rd toggle, wr toggle, scl, sda, straps
  localparam logic [6:0] SYNC_RST = 7'h4c;

  typedef struct packed {
    logic [7:0] motion;
    logic [7:0] delta_y;
    logic [7:0] delta_x;
    logic [7:0] surface_quality_count;
    logic [7:0] shutter_hi;
    logic [7:0] shutter_lo;
    logic [7:0] max_pixel;
  } sshp_nav_s;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } sshp_wr_s;

  typedef struct packed {
    logic        burst;
    logic [55:0] data;
  } sshp_rd_s;

  typedef struct packed {
    logic [6:0] cnt;
    logic [7:0] sh;
    logic       wr_dir;
    logic       done;
  } sshp_spi_s;

  typedef enum logic [2:0] {
    T_IDLE, T_DEV, T_REG, T_WDAT, T_RDAT, T_ACK, T_MACK
  } sshp_twi_e;

  typedef struct packed {
    logic [127:0][7:0] regs;
    sshp_rd_s          rd;
    logic              rd_seen;
    logic              wr_seen;
    logic              locked;
    logic [7:0]        exit_cnt;
    logic [6:0]        slave_id;
    logic              id_done;
    logic              scl_q;
    logic              sda_q;
    sshp_twi_e         ts;
    sshp_twi_e         ack_to;
    logic [3:0]        cnt;
    logic [7:0]        sh;
    logic [7:0]        tx;
    logic [6:0]        taddr;
    logic              ai;
    logic              mack_ok;
    logic              sda_oe;
    logic              sda_lvl;
  } sshp_core_s;

endpackage

// ===== test/sshp_chk_asserts.sv
// pin-level checks on the serial host port
`timescale 1ns/1ns
module sshp_chk (
  // core clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // four-wire link
  input wire logic sclk,
  input wire logic port_select_n,
  input wire logic miso_out,
  input wire logic miso_oe,
  // two-wire link
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe,
  // status
  input wire logic burst_locked
);
  logic [7:0] hi_cnt_reg;
  // consecutive core cycles with select high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt_reg <= 8'h00;
    end else if (!port_select_n) begin
      hi_cnt_reg <= 8'h00;
    end else if (hi_cnt_reg != 8'hff) begin
      hi_cnt_reg <= hi_cnt_reg + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_oe_quiet;
    port_select_n && $past(port_select_n) |-> !miso_oe;
  endproperty
  a_oe_quiet: assert property (p_oe_quiet)
    else $error("miso driven while deselected");
  property p_miso_hold;
    !port_select_n && $past(!port_select_n) && sclk && $past(sclk)
      |-> $stable(miso_out);
  endproperty
  a_miso_hold: assert property (p_miso_hold)
    else $error("miso changed while sclk high");
  property p_oe_fall;
    $rose(miso_oe) |-> !sclk;
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("miso enabled off a falling edge");
  property p_lock_set;
    $rose(burst_locked) |-> !port_select_n;
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("burst lock set while deselected");
  property p_lock_hold;
    burst_locked && !port_select_n |=> burst_locked;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("burst lock dropped while selected");
  property p_exit_early;
    $fell(burst_locked) |-> hi_cnt_reg >= 8'h7d && hi_cnt_reg <= 8'h86;
  endproperty
  a_exit_early: assert property (p_exit_early)
    else $error("burst lock cleared at wrong time");
  property p_exit_late;
    hi_cnt_reg > 8'h88 |-> !burst_locked;
  endproperty
  a_exit_late: assert property (p_exit_late)
    else $error("burst lock held past exit time");
  property p_sda_stable;
    scl && $past(scl) |-> $stable(sda_oe);
  endproperty
  a_sda_stable: assert property (p_sda_stable)
    else $error("sda changed while scl high");
  property p_sda_rise;
    $rose(sda_oe) |-> !scl && $past(!scl, 2);
  endproperty
  a_sda_rise: assert property (p_sda_rise)
    else $error("sda pulled outside scl low");
  property p_sda_low;
    sda_oe |-> !sda_out;
  endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("sda driven high");
endmodule
bind sshp_host_port sshp_chk u_sshp_chk (
  .clk(clk), .rst_n(rst_n), .sclk(sclk), .port_select_n(port_select_n),
  .miso_out(miso_out), .miso_oe(miso_oe), .scl(scl), .sda_out(sda_out),
  .sda_oe(sda_oe), .burst_locked(burst_locked)
);

// ===== test/sshp_host_port_tb.sv
// self-checking bench for the serial host port
`timescale 1ns/1ns
module sshp_host_port_tb;
  logic                clk;
  logic                rst_n;
  logic                sclk;
  logic                port_select_n;
  logic                mosi;
  logic                miso_out;
  logic                miso_oe;
  logic                scl;
  logic                sda_in;
  logic                sda_out;
  logic                sda_oe;
  logic                burst_locked;
  sshp_pkg::sshp_nav_s nav;
  logic [55:0]         q;
  logic [7:0]          b;
  logic                ak;
  logic [1:0]          straps;
  int                  errors;
  int                  checks;
  sshp_host_port u_sshp_host_port (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .port_select_n(port_select_n),
    .mosi(mosi), .miso_out(miso_out), .miso_oe(miso_oe), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .strap_addr_sel_low(straps[1]), .strap_addr_sel_high(straps[0]),
    .nav(nav), .burst_locked(burst_locked)
  );
  sshp_mst u_sshp_mst (
    .clk(clk), .sclk(sclk), .port_select_n(port_select_n), .mosi(mosi),
    .miso_out(miso_out), .miso_oe(miso_oe), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe)
  );
  initial clk = 1'b0;
  always #2 clk = ~clk;
  task automatic chk(input string nm, input logic [55:0] e,
                     input logic [55:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic tw(input logic [7:0] tx);
    u_sshp_mst.twi_byte(tx, 1'b1, b, ak);
  endtask
  task automatic t_rw;
    u_sshp_mst.rd(7'h1c, 1, q);
    chk("io mode", 56'(sshp_pkg::PORT_IO_MODE_RST), q);
    u_sshp_mst.wr(7'h30, 8'ha5);
    u_sshp_mst.rd(7'h30, 1, q);
    chk("reg 30", 56'ha5, q);
    u_sshp_mst.rd(7'h05, 1, q);
    chk("surface_quality_count", 56'(nav.surface_quality_count), q);
  endtask
  task automatic t_abort;
    u_sshp_mst.abort4;
    u_sshp_mst.rd(7'h30, 1, q);
    chk("after abort", 56'ha5, q);
  endtask
  task automatic t_burst;
    u_sshp_mst.wr(7'h1c, sshp_pkg::BURST_ENABLE_VAL);
    u_sshp_mst.rd(7'h02, 7, q);
    chk("burst", nav, q);
    chk("lock", 56'h0, 56'(burst_locked));
    u_sshp_mst.rd(7'h02, 3, q);
    chk("short burst", 56'(nav[55:32]), q);
    u_sshp_mst.rd(7'h05, 1, q);
    chk("after burst", 56'(nav.surface_quality_count), q);
  endtask
  task automatic t_twi;
    u_sshp_mst.twi_start;
    tw(8'hae);
    chk("id ack", 56'h0, 56'(ak));
    tw(8'h31);
    chk("reg ack", 56'h0, 56'(ak));
    tw(8'h5a);
    chk("data ack", 56'h0, 56'(ak));
    u_sshp_mst.twi_stop;
    u_sshp_mst.twi_start;
    tw(8'hae);
    tw(8'h31);
    u_sshp_mst.twi_start;
    tw(8'haf);
    chk("read ack", 56'h0, 56'(ak));
    tw(8'hff);
    chk("twi read", 56'h5a, 56'(b));
    u_sshp_mst.twi_stop;
    u_sshp_mst.twi_start;
    tw(8'h66);
    chk("wrong id", 56'h1, 56'(ak));
    u_sshp_mst.twi_stop;
    straps = 2'b00;
    u_sshp_mst.tick(20);
    u_sshp_mst.twi_start;
    tw(8'h66);
    chk("strap id ack", 56'h0, 56'(ak));
    u_sshp_mst.twi_stop;
    u_sshp_mst.rd(7'h31, 1, q);
    chk("shared reg", 56'h5a, q);
  endtask
  initial begin
    #300000;
    errors++;
    $display("ERROR watchdog expected done seen timeout");
    summarize;
  end
  initial begin
    errors = 0;
    checks = 0;
    rst_n = 1'b0;
    straps = 2'b11;
    nav = 56'h8112233445566f;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (10) @(posedge clk);
    t_rw;
    t_abort;
    t_burst;
    t_twi;
    summarize;
  end
endmodule

// ===== test/sshp_mst.sv
// host master model for both serial links
`timescale 1ns/1ns
module sshp_mst (
  // core clock for pacing
  input  wire logic clk,
  // four-wire link
  output logic      sclk,
  output logic      port_select_n,
  output logic      mosi,
  input  wire logic miso_out,
  input  wire logic miso_oe,
  // two-wire link
  output logic      scl,
  output logic      sda_in,
  input  wire logic sda_out,
  input  wire logic sda_oe
);
  localparam int H = 15;
  logic sda_h;
  // pulled-up wire, low while the device pulls it
  assign sda_in = sda_h & ~(sda_oe & ~sda_out);
  initial begin
    sclk = 1'b1;
    port_select_n = 1'b1;
    mosi = 1'b0;
    scl = 1'b1;
    sda_h = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // clock idles high, data out on fall, sampled on rise
  task automatic sbits(input logic [7:0] tx, input int n,
                       output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      #7;
      sclk = 1'b1;
      rx[i] = miso_oe ? miso_out : 1'bz;
      #8;
    end
    mosi = ~mosi;
  endtask
  task automatic sel(input logic v);
    tick(1);
    port_select_n = v;
    #120;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    sel(1'b0);
    sbits({1'b1, a}, 8, x);
    sbits(d, 8, x);
    #100;
    sel(1'b1);
    #30000;
  endtask
  task automatic rd(input logic [6:0] a, input int n,
                    output logic [55:0] q);
    logic [7:0] x;
    q = '0;
    sel(1'b0);
    sbits({1'b0, a}, 8, x);
    #4000;
    for (int i = 0; i < n; i++) begin
      sbits(8'h00, 8, x);
      q = {q[47:0], x};
    end
    sel(1'b1);
    #600;
  endtask
  task automatic abort4;
    logic [7:0] x;
    sel(1'b0);
    sbits(8'h30, 4, x);
    sel(1'b1);
    #600;
  endtask
  task automatic twi_start;
    sda_h = 1'b1;
    tick(H);
    scl = 1'b1;
    tick(H);
    sda_h = 1'b0;
    tick(H);
    scl = 1'b0;
    tick(H);
  endtask
  task automatic twi_stop;
    sda_h = 1'b0;
    tick(H);
    scl = 1'b1;
    tick(H);
    sda_h = 1'b1;
    tick(H);
  endtask
  // eight bits msb first then the acknowledge slot
  task automatic twi_byte(input logic [7:0] tx, input logic ab,
                          output logic [7:0] rx, output logic ak);
    logic [8:0] s;
    logic [8:0] r;
    s = {tx, ab};
    for (int i = 8; i >= 0; i--) begin
      sda_h = s[i];
      tick(H);
      scl = 1'b1;
      tick(H);
      r[i] = sda_in;
      scl = 1'b0;
      tick(H);
    end
    rx = r[8:1];
    ak = r[0];
  endtask
endmodule
